// >>> hdl/tacs_pkg.sv
// Purpose: Shared constants and types for the touch converter sequencer.
// Assumes: Core clock of 10 MHz.
// Notes: Register offsets are byte addresses on the serial link.
package tacs_pkg;
	// ****************************************
	// Clock and timing.
	// ****************************************
	localparam int CLK_MHZ = 10; // Core clock rate in MHz.
	localparam int OSC_OFF_US = 20; // Oscillator run-on after a sequence.
	localparam int OSC_OFF_CYC = OSC_OFF_US * CLK_MHZ;
	// Sample spacing choices, in microseconds.
	localparam int SPACE_US [8] = '{0, 5, 10, 20, 50, 100, 200, 500};
	localparam int LONG_SPACE_CYC = SPACE_US[7] * CLK_MHZ;
	// ****************************************
	// Register map and fields.
	// ****************************************
	localparam logic [7:0] REG_CFG = 8'h01; // Driver hold setup.
	localparam logic [7:0] REG_SEQCMD = 8'h02; // Sequence command.
	localparam logic [7:0] REG_STATUS = 8'h10; // Channel and state.
	localparam logic [7:0] REG_SEQ_FIRST = 8'h11; // First result byte.
	localparam logic [7:0] REG_SEQ_LAST = 8'h18; // Last result byte.
	localparam logic [7:0] REG_SGL_FIRST = 8'h20; // First single byte.
	localparam logic [7:0] REG_SGL_LAST = 8'h29; // Last single byte.
	localparam int CFG_HOLD_BIT = 0; // Driver hold bit position.
	localparam int CMD_COUNT_BIT = 7; // Ten-sample select.
	localparam int CMD_SEQM_LSB = 4; // Channel sequence field.
	localparam int CMD_SPACE_LSB = 0; // Sample spacing field.
	// Serial clock counts since a fresh start.
	localparam logic [4:0] SCL_OSC_ON = 5'h19; // 25th clock.
	localparam logic [4:0] SCL_SAMPLE = 5'h1a; // 26th clock.
	localparam logic [4:0] SCL_SAT = 5'h1f; // Counter ceiling.
	// Slave address upper bits; value is arbitrary.
	localparam logic [5:0] SLAVE_BASE = 6'h24;
	// Sequence state field codes.
	localparam logic [3:0] ST_IDLE = 4'h0;
	localparam logic [3:0] ST_BUSY = 4'h1;
	localparam logic [3:0] ST_AVAIL = 4'h2;
	// Channel codes as reported in status.
	localparam logic [3:0] CH_AIN = 4'h3;
	localparam logic [3:0] CH_X = 4'h4;
	localparam logic [3:0] CH_Y = 4'h5;
	localparam logic [3:0] CH_Z1 = 4'h6;
	localparam logic [3:0] CH_Z2 = 4'h7;
	localparam logic [3:0] SMP_SHORT = 4'h6; // Samples, count bit 0.
	localparam logic [3:0] SMP_LONG = 4'ha; // Samples, count bit 1.
	localparam logic [11:0] ADC_FULL = 12'hfff; // Largest code.
	// ****************************************
	// Types.
	// ****************************************
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00, SQ_WAIT = 2'b01, SQ_CONV = 2'b10, SQ_HOLD = 2'b11
	} tacs_seq_t;
	typedef enum logic [1:0] {
		ES_IDLE = 2'b00, ES_RX = 2'b01, ES_TX = 2'b10, ES_HACK = 2'b11
	} tacs_eng_t;
endpackage : tacs_pkg

// >>> hdl/tacs_i2c_engine.sv
// Purpose: Serial slave bit engine: framing, shifting and acknowledge.
// Assumes: Pins are asynchronous and are synchronised here.
// Notes: Events are one-cycle pulses on the core clock.
`timescale 1ns/100ps
module tacs_i2c_engine import tacs_pkg::*; (
	input wire logic core_clk, // Core clock.
	input wire logic srst, // Synchronous reset, high.
	input wire logic sclPin, // Serial clock pin.
	input wire logic sdaPin, // Serial data pin level.
	input wire logic cad0Pin, // Address strap pin.
	input wire logic [7:0] txData, // Byte to send on load.
	output logic sdaOe, // Pull data low when high.
	output logic evStart, // Start or repeated start.
	output logic evStop, // Stop condition.
	output logic evByte, // Byte taken, ack slot begins.
	output logic [7:0] rxData, // Byte taken.
	output logic rxIsAddr, // Byte was the address.
	output logic evTxLoad, // Next byte is loaded.
	output logic evHostAck, // Host ack slot sampled.
	output logic hostAck, // Host acknowledged.
	output logic sclRise, // Serial clock rose.
	output logic sclFall, // Serial clock fell.
	output logic [4:0] sclCount // Rises since a fresh start.
);
	// ****************************************
	// Synchronisers and edge finding.
	// ****************************************
	logic [1:0] sclSy_q, sdaSy_q, cadSy_q; // Two-flop synchronisers.
	logic sclP_q, sdaP_q; // Previous synchronised levels.
	logic sclS, sdaS, startC, stopC; // Clean levels and conditions.
	tacs_eng_t st_q, st_d; // Engine state.
	logic [3:0] cnt_q, cnt_d; // Bit position in byte.
	logic [7:0] sh_q, sh_d; // Shift register.
	logic oe_q, oe_d, adr_q, adr_d, rd_q, rd_d, free_q, free_d;
	logic [4:0] sc_q, sc_d; // Serial clock count.

	assign sclS = sclSy_q[1];
	assign sdaS = sdaSy_q[1];
	assign sclRise = sclS & ~sclP_q;
	assign sclFall = ~sclS & sclP_q;
	// Data moving while the clock stays high frames a transfer.
	assign startC = sclS & sclP_q & sdaP_q & ~sdaS;
	assign stopC = sclS & sclP_q & ~sdaP_q & sdaS;
	assign sdaOe = oe_q;
	assign rxData = sh_q;
	assign rxIsAddr = adr_q;
	assign sclCount = sc_q;

	// Next-state logic of the byte engine.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		oe_d = oe_q;
		adr_d = adr_q;
		rd_d = rd_q;
		free_d = free_q;
		sc_d = sc_q;
		evStart = 1'b0;
		evStop = 1'b0;
		evByte = 1'b0;
		evTxLoad = 1'b0;
		evHostAck = 1'b0;
		hostAck = 1'b0;
		// A repeated start keeps counting; only a fresh start clears.
		if (sclRise && sc_q != SCL_SAT) begin
			sc_d = sc_q + 5'h01;
		end
		if (stopC) begin
			st_d = ES_IDLE;
			oe_d = 1'b0;
			free_d = 1'b1;
			evStop = 1'b1;
		end else if (startC) begin
			st_d = ES_RX;
			cnt_d = 4'h0;
			adr_d = 1'b1;
			oe_d = 1'b0;
			free_d = 1'b0;
			evStart = 1'b1;
			if (free_q) begin
				sc_d = 5'h00;
			end
		end else begin
			case (st_q)
				ES_RX: begin
					if (sclRise && cnt_q < 4'h8) begin
						sh_d = {sh_q[6:0], sdaS};
						cnt_d = cnt_q + 4'h1;
					end else if (sclFall && cnt_q == 4'h8) begin
						if (adr_q && sh_q[7:1] != {SLAVE_BASE, cadSy_q[1]}) begin
							st_d = ES_IDLE; // Not our address.
						end else begin
							evByte = 1'b1;
							oe_d = 1'b1;
							cnt_d = 4'h9;
							rd_d = adr_q ? sh_q[0] : rd_q;
						end
					end else if (sclFall && cnt_q == 4'h9) begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						adr_d = 1'b0;
						if (adr_q && rd_q) begin
							evTxLoad = 1'b1;
							sh_d = txData;
							oe_d = ~txData[7];
							cnt_d = 4'h1;
							st_d = ES_TX;
						end
					end
				end
				ES_TX: begin
					if (sclFall && cnt_q < 4'h8) begin
						oe_d = ~sh_q[6];
						sh_d = {sh_q[6:0], 1'b0};
						cnt_d = cnt_q + 4'h1;
					end else if (sclFall) begin
						oe_d = 1'b0;
						st_d = ES_HACK;
					end
				end
				ES_HACK: begin
					// A missing acknowledge ends the read.
					if (sclRise) begin
						evHostAck = 1'b1;
						hostAck = ~sdaS;
						st_d = sdaS ? ES_IDLE : ES_HACK;
					end else if (sclFall) begin
						evTxLoad = 1'b1;
						sh_d = txData;
						oe_d = ~txData[7];
						cnt_d = 4'h1;
						st_d = ES_TX;
					end
				end
				default: begin
					st_d = ES_IDLE;
				end
			endcase
		end
	end

	// Registers of the engine and its synchronisers.
	always_ff @(posedge core_clk) begin
		sclSy_q <= srst ? 2'b11 : {sclSy_q[0], sclPin};
		sdaSy_q <= srst ? 2'b11 : {sdaSy_q[0], sdaPin};
		cadSy_q <= srst ? 2'b00 : {cadSy_q[0], cad0Pin};
		if (srst) begin
			sclP_q <= 1'b1;
			sdaP_q <= 1'b1;
			st_q <= ES_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			oe_q <= 1'b0;
			adr_q <= 1'b0;
			rd_q <= 1'b0;
			free_q <= 1'b1;
			sc_q <= 5'h00;
		end else begin
			sclP_q <= sclS;
			sdaP_q <= sdaS;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			oe_q <= oe_d;
			adr_q <= adr_d;
			rd_q <= rd_d;
			free_q <= free_d;
			sc_q <= sc_d;
		end
	end
endmodule : tacs_i2c_engine

// >>> hdl/tacs_sequencer.sv
// Purpose: Control sequencer of a resistive touch converter.
// Assumes: Converter macro answers on the core clock.
// Notes: Pen output is active low; touch sense is active high.
// What this block does
// - Driver hold takes effect at 27th rise.
// - Pointer write then read starts single conversion.
// - Oscillator starts at 25th clock fall.
// - Sample and convert after 26th clock rise.
// - Result sent high byte, then low nibble.
// - Continuous reads end on nack and stop.
// - Sequence command starts run, pen low.
// - Six or ten samples, trimmed average stored.
// - Completion raises pen; oscillator off later.
// - Each read byte advances the pointer; single pairs alternate.
// - Nack with stop ends register transmission.
// - Results clear after all bytes read.
// - Pen follows touch when idle, hold off.
// - Conversion, sequence or hold force pen low.
// - Single mode disables pen from 26th rise.
// - State field: idle, busy, available codes.
// - Hold bit selects auto power-down or drivers.
`timescale 1ns/100ps
module tacs_sequencer import tacs_pkg::*; #(
	parameter int LONG_SPACE = LONG_SPACE_CYC // Longest spacing, cycles.
) (
	input wire logic core_clk, // Core clock.
	input wire logic srst, // Synchronous reset, high.
	input wire logic sclPin, // Serial clock pin.
	input wire logic sdaPin, // Serial data pin level.
	output logic sdaOut, // Data pin drive value.
	output logic sdaOe, // Data pin pulled low when high.
	input wire logic cad0Pin, // Address strap pin.
	input wire logic penSensePin, // Panel touched, high.
	output logic penTouchN, // Pen output, low active.
	output logic oscOn, // Internal oscillator enable.
	output logic driverOn, // Panel driver switches on.
	output logic convStart, // Start one conversion.
	output logic [3:0] convChan, // Channel to convert.
	input wire logic convDone, // Conversion finished.
	input wire logic [11:0] convData // Conversion result.
);
	// ****************************************
	// Decoding helpers.
	// ****************************************
	// Pointer lies in the sequence result bytes.
	function automatic logic inSeq(input logic [7:0] p);
		return p >= REG_SEQ_FIRST && p <= REG_SEQ_LAST;
	endfunction : inSeq
	// Pointer lies in the single result bytes.
	function automatic logic inSgl(input logic [7:0] p);
		return p >= REG_SGL_FIRST && p <= REG_SGL_LAST;
	endfunction : inSgl
	// Channel of a single result pair.
	function automatic logic [3:0] sglChan(input logic [7:0] p);
		logic [7:0] k;
		k = (p - REG_SGL_FIRST) >> 1;
		case (k[2:0])
			3'h0: return CH_X;
			3'h1: return CH_Y;
			3'h2: return CH_Z1;
			3'h3: return CH_Z2;
			default: return CH_AIN;
		endcase
	endfunction : sglChan
	// Number of channels that a sequence selection scans.
	function automatic logic [2:0] chanCnt(input logic [2:0] m);
		return (m > 3'h3) ? 3'h4 : m + 3'h1;
	endfunction : chanCnt
	// Channel at a given slot of the scan.
	function automatic logic [3:0] slotChan(input logic [1:0] s);
		return CH_X + {2'b00, s};
	endfunction : slotChan
	// Spacing between samples in cycles, at least one.
	function automatic logic [12:0] spaceCyc(input logic [2:0] s);
		int c;
		c = (s == 3'h7) ? LONG_SPACE : SPACE_US[s] * CLK_MHZ;
		return (c < 1) ? 13'h0001 : 13'(c);
	endfunction : spaceCyc

	// ****************************************
	// Serial engine.
	// ****************************************
	logic evStart, evStop, evByte, rxIsAddr, evTxLoad; // Engine events.
	logic evHostAck, hostAck, sclRise, sclFall; // Engine events.
	logic [7:0] rxData, txData; // Byte paths.
	logic [4:0] sclCnt; // Clock count since fresh start.

	tacs_i2c_engine tacs_i2c_engine_inst (
		.core_clk(core_clk), .srst(srst), .sclPin(sclPin),
		.sdaPin(sdaPin), .cad0Pin(cad0Pin), .txData(txData),
		.sdaOe(sdaOe), .evStart(evStart), .evStop(evStop),
		.evByte(evByte), .rxData(rxData), .rxIsAddr(rxIsAddr),
		.evTxLoad(evTxLoad), .evHostAck(evHostAck), .hostAck(hostAck),
		.sclRise(sclRise), .sclFall(sclFall), .sclCount(sclCnt)
	);
	// Open-drain pin: only ever pulled low.
	assign sdaOut = 1'b0;

	// ****************************************
	// Host registers and single mode.
	// ****************************************
	logic [7:0] ptr_q, ptr_d, pend_q, pend_d, cmd_q, cmd_d; // Pointer etc.
	logic wIdx_q, wIdx_d, pendV_q, pendV_d; // Pointer set, write pending.
	logic hold_q, hold_d; // Driver hold setting.
	logic sgBusy_q, sgBusy_d, osc1_q, osc1_d; // Single conversion state.
	logic [11:0] sgRes_q, sgRes_d; // Last single result.
	logic [3:0] chst_q, chst_d, sgCh_q, sgCh_d; // Channel codes.
	logic sgStart, seqGo, clrSeq, seqConv; // Internal pulses.
	logic sglSel; // Pointer in single area.
	logic [7:0] lastSeq; // Last result byte of this scan.
	logic [3:0] stat_q, stat_d; // Sequence state field.
	logic [11:0] res_q [4]; // Averaged results.
	logic [11:0] res_d [4]; // Next averaged results.

	assign sglSel = inSgl(ptr_q);
	assign lastSeq = REG_SEQ_FIRST + {4'h0, chanCnt(cmd_q[CMD_SEQM_LSB +: 3]), 1'b0}
		- 8'h01;

	// Next values of the host-facing registers.
	always_comb begin
		ptr_d = ptr_q;
		pend_d = pend_q;
		cmd_d = cmd_q;
		wIdx_d = wIdx_q;
		pendV_d = pendV_q;
		hold_d = hold_q;
		sgBusy_d = sgBusy_q;
		osc1_d = osc1_q;
		sgRes_d = sgRes_q;
		chst_d = chst_q;
		sgCh_d = sgCh_q;
		sgStart = 1'b0;
		seqGo = 1'b0;
		clrSeq = 1'b0;
		// First byte after the address is the pointer.
		if (evByte && rxIsAddr) begin
			wIdx_d = 1'b0;
		end else if (evByte && !wIdx_q) begin
			ptr_d = rxData;
			wIdx_d = 1'b1;
		end else if (evByte) begin
			pend_d = rxData;
			pendV_d = 1'b1;
		end
		// Writes land on the acknowledge rise, the 27th clock.
		if (sclRise && pendV_q) begin
			pendV_d = 1'b0;
			ptr_d = ptr_q + 8'h01;
			if (ptr_q == REG_CFG) begin
				hold_d = pend_q[CFG_HOLD_BIT];
			end
			if (ptr_q == REG_SEQCMD) begin
				cmd_d = pend_q;
				seqGo = 1'b1;
			end
		end
		if (sclFall && sclCnt == SCL_OSC_ON && sglSel && wIdx_q) begin
			osc1_d = 1'b1;
		end
		// The count still holds the rises before this one.
		if (sclRise && sclCnt + 5'h01 == SCL_SAMPLE && sglSel && osc1_q) begin
			sgStart = 1'b1;
			sgBusy_d = 1'b1;
			sgCh_d = sglChan(ptr_q);
		end
		// Single pairs alternate; sequence bytes walk forward.
		if (evTxLoad && sglSel) begin
			ptr_d = ptr_q[0] ? ptr_q - 8'h01 : ptr_q + 8'h01;
		end else if (evTxLoad) begin
			ptr_d = ptr_q + 8'h01;
			clrSeq = inSeq(ptr_q) && ptr_q == lastSeq;
		end
		// Acknowledge after a low byte asks for a fresh result.
		if (evHostAck && hostAck && sglSel && !ptr_q[0] && !sgBusy_q) begin
			sgStart = 1'b1;
			sgBusy_d = 1'b1;
			osc1_d = 1'b1;
			sgCh_d = sglChan(ptr_q);
		end
		if (convDone && sgBusy_q) begin
			sgBusy_d = 1'b0;
			sgRes_d = convData;
			chst_d = sgCh_q;
			osc1_d = 1'b0;
		end
		// Stop ends the continuous readback once idle.
		if (evStop && !sgBusy_q) begin
			osc1_d = 1'b0;
		end
	end

	// Read data for the byte the engine loads next.
	always_comb begin
		logic [7:0] k;
		logic [11:0] r;
		k = ptr_q - REG_SEQ_FIRST;
		r = 12'h000;
		txData = 8'h00;
		if (ptr_q == REG_CFG) begin
			txData = {7'h00, hold_q};
		end else if (ptr_q == REG_SEQCMD) begin
			txData = cmd_q;
		end else if (ptr_q == REG_STATUS) begin
			txData = {chst_q, stat_q};
		end else if (inSeq(ptr_q)) begin
			r = res_q[k[2:1]];
			txData = k[0] ? {r[3:0], 4'h0} : r[11:4];
		end else if (sglSel) begin
			txData = ptr_q[0] ? {sgRes_q[3:0], 4'h0} : sgRes_q[11:4];
		end
	end

	// ****************************************
	// Sequence mode.
	// ****************************************
	tacs_seq_t sq_q, sq_d; // Sequence state.
	logic [1:0] slot_q, slot_d; // Channel slot.
	logic [3:0] smp_q, smp_d; // Samples taken.
	logic [15:0] sum_q, sum_d, trim; // Sample sum and trimmed sum.
	logic [11:0] mn_q, mn_d, mx_q, mx_d, nMn, nMx; // Extremes.
	logic [12:0] spc_q, spc_d; // Wait counter.
	logic [3:0] nSmp; // Samples per channel.

	assign nSmp = cmd_q[CMD_COUNT_BIT] ? SMP_LONG : SMP_SHORT;
	assign nMn = (convData < mn_q) ? convData : mn_q;
	assign nMx = (convData > mx_q) ? convData : mx_q;
	assign trim = sum_q + {4'h0, convData} - {4'h0, nMn} - {4'h0, nMx};

	// Next values of the sequence engine.
	always_comb begin
		sq_d = sq_q;
		slot_d = slot_q;
		smp_d = smp_q;
		sum_d = sum_q;
		mn_d = mn_q;
		mx_d = mx_q;
		spc_d = spc_q;
		stat_d = stat_q;
		res_d = res_q;
		seqConv = 1'b0;
		// Clearing comes first so that any new event wins.
		if (clrSeq) begin
			stat_d = ST_IDLE;
			res_d = '{default: 12'h000};
		end
		case (sq_q)
			SQ_WAIT: begin
				spc_d = spc_q - 13'h0001;
				if (spc_q == 13'h0000) begin
					seqConv = 1'b1;
					sq_d = SQ_CONV;
				end
			end
			SQ_CONV: begin
				if (convDone && !sgBusy_q) begin
					sum_d = sum_q + {4'h0, convData};
					mn_d = nMn;
					mx_d = nMx;
					smp_d = smp_q + 4'h1;
					sq_d = SQ_WAIT;
					spc_d = spaceCyc(cmd_q[CMD_SPACE_LSB +: 3]);
					if (smp_d == nSmp) begin
						// Trimmed sum over four or eight samples.
						res_d[slot_q] = cmd_q[CMD_COUNT_BIT] ? trim[14:3]
							: trim[13:2];
						slot_d = slot_q + 2'h1;
						smp_d = 4'h0;
						sum_d = 16'h0000;
						mn_d = ADC_FULL;
						mx_d = 12'h000;
						if ({1'b0, slot_q} + 3'h1 == chanCnt(cmd_q[CMD_SEQM_LSB +: 3])) begin
							sq_d = SQ_HOLD;
							spc_d = 13'(OSC_OFF_CYC);
							stat_d = ST_AVAIL;
						end
					end
				end
			end
			SQ_HOLD: begin
				spc_d = spc_q - 13'h0001;
				if (spc_q == 13'h0000) begin
					sq_d = SQ_IDLE;
				end
			end
			default: begin
				sq_d = SQ_IDLE;
			end
		endcase
		if (seqGo) begin
			sq_d = SQ_WAIT;
			stat_d = ST_BUSY;
			slot_d = 2'h0;
			smp_d = 4'h0;
			sum_d = 16'h0000;
			mn_d = ADC_FULL;
			mx_d = 12'h000;
			spc_d = spaceCyc(cmd_d[CMD_SPACE_LSB +: 3]);
		end
	end

	// ****************************************
	// Pen output and drive lines.
	// ****************************************
	logic [1:0] touchSy_q; // Touch sense synchroniser.
	logic seqRun, penLow; // Sequence measuring, pen pulled low.

	assign seqRun = sq_q == SQ_WAIT || sq_q == SQ_CONV;
	// Pen shows touch only when idle with hold off; after a
	// sequence it stays high until the oscillator is down.
	assign penLow = hold_q || sgBusy_q || seqRun
		|| (sq_q != SQ_HOLD && touchSy_q[1]);

	// All registers of the block.
	always_ff @(posedge core_clk) begin
		touchSy_q <= srst ? 2'b00 : {touchSy_q[0], penSensePin};
		if (srst) begin
			{ptr_q, pend_q, cmd_q} <= {8'h00, 8'h00, 8'h00};
			{wIdx_q, pendV_q, hold_q, sgBusy_q, osc1_q} <= 5'h00;
			sgRes_q <= 12'h000;
			chst_q <= 4'h0;
			sgCh_q <= 4'h0;
			sq_q <= SQ_IDLE;
			slot_q <= 2'h0;
			smp_q <= 4'h0;
			stat_q <= ST_IDLE;
			sum_q <= 16'h0000;
			mn_q <= ADC_FULL;
			mx_q <= 12'h000;
			spc_q <= 13'h0000;
			res_q <= '{default: 12'h000};
			penTouchN <= 1'b1;
			oscOn <= 1'b0;
			driverOn <= 1'b0;
			convStart <= 1'b0;
			convChan <= 4'h0;
		end else begin
			{ptr_q, pend_q, cmd_q} <= {ptr_d, pend_d, cmd_d};
			{wIdx_q, pendV_q, hold_q} <= {wIdx_d, pendV_d, hold_d};
			{sgBusy_q, osc1_q} <= {sgBusy_d, osc1_d};
			sgRes_q <= sgRes_d;
			chst_q <= chst_d;
			sgCh_q <= sgCh_d;
			sq_q <= sq_d;
			slot_q <= slot_d;
			smp_q <= smp_d;
			stat_q <= stat_d;
			sum_q <= sum_d;
			mn_q <= mn_d;
			mx_q <= mx_d;
			spc_q <= spc_d;
			res_q <= res_d;
			penTouchN <= ~penLow;
			oscOn <= osc1_d || sq_d != SQ_IDLE;
			driverOn <= hold_d || sgBusy_d || sq_d == SQ_WAIT
				|| sq_d == SQ_CONV;
			convStart <= sgStart || seqConv;
			convChan <= sgStart ? sgCh_d : slotChan(slot_q);
		end
	end

	// ****************************************
	// Checks.
	// ****************************************
	localparam int HOLD_WAIT = OSC_OFF_CYC;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence sampleRise;
		sclRise && sclCnt + 5'h01 == SCL_SAMPLE && sglSel && osc1_q;
	endsequence
	sequence convBegun;
		sgBusy_q && convStart ##1 !convStart;
	endsequence

	a_hold_pen_low: assert property (hold_q |=> !penTouchN)
		else $error("pen not low while hold set");
	a_seq_pen_low: assert property (seqRun |=> !penTouchN)
		else $error("pen not low during sequence");
	a_done_pen_high: assert property (
		$rose(sq_q == SQ_HOLD) && !hold_q && !sgBusy_q |=> penTouchN)
		else $error("pen not high at sequence end");
	a_osc_off_wait: assert property (
		$rose(sq_q == SQ_HOLD) |-> spc_q == 13'(HOLD_WAIT))
		else $error("oscillator run-on wrong");
	a_osc_on_25: assert property (
		sclFall && sclCnt == SCL_OSC_ON && sglSel && wIdx_q |=> osc1_q)
		else $error("oscillator not on at clock 25");
	a_conv_at_26: assert property (sampleRise |=> convBegun)
		else $error("conversion not begun at clock 26");
	a_hold_at_27: assert property (
		sclRise && pendV_q && ptr_q == REG_CFG
		|=> hold_q == $past(pend_q[CFG_HOLD_BIT]))
		else $error("hold bit not taken");
	a_state_code: assert property (
		stat_q == ST_IDLE || stat_q == ST_BUSY || stat_q == ST_AVAIL)
		else $error("reserved state code");
	a_ptr_step: assert property (
		evTxLoad && inSeq(ptr_q) |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not advance");
	a_low_byte: assert property (
		evTxLoad && sglSel && ptr_q[0] |-> txData[3:0] == 4'h0)
		else $error("low byte tail not zero");
	a_pen_release: assert property (
		sq_q == SQ_IDLE && !hold_q && !sgBusy_q && !touchSy_q[1]
		|=> penTouchN)
		else $error("pen not released");
endmodule : tacs_sequencer

// >>> verif/tacs_host_model.sv
// Purpose: Host master model for the serial register link.
// Assumes: Clock idles high and stands still between frames.
// Notes: Data is open drain; the bench resolves it with a pull-up.
`timescale 1ns/100ps
module tacs_host_model (
	input wire logic core_clk, // Core clock.
	input wire logic sdaPin, // Resolved data wire.
	output logic sclPin, // Serial clock, 800 ns bit.
	output logic sdaPull // High pulls data low.
);
	initial begin
		sclPin = 1'b1;
		sdaPull = 1'b0;
	end
	// Waits n core cycles; every change lands just after an edge.
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask : hold
	// Data is released before the clock rises, so a slow ack is no stop.
	task automatic start();
		sdaPull <= 1'b0;
		hold(4);
		sclPin <= 1'b1;
		hold(2);
		sdaPull <= 1'b1;
		hold(2);
		sclPin <= 1'b0;
		hold(2);
	endtask : start
	task automatic stop();
		sdaPull <= 1'b1;
		hold(2);
		sclPin <= 1'b1;
		hold(4);
		sdaPull <= 1'b0;
		hold(4);
	endtask : stop
	// One bit: data set while the clock is low, sampled at end of high.
	task automatic bitx(input logic b, output logic s);
		sdaPull <= !b;
		hold(2);
		sclPin <= 1'b1;
		hold(4);
		s = sdaPin;
		sclPin <= 1'b0;
		hold(2);
	endtask : bitx
	// Eight bits out and in, then the ninth slot with a9 driven.
	task automatic xbyte(input logic [7:0] tx, input logic a9,
		output logic [7:0] rx, output logic s9);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(a9, s9);
	endtask : xbyte
endmodule : tacs_host_model

// >>> verif/test_tacs_sequencer.sv
// Purpose: Self-checking bench of the touch converter sequencer.
// Assumes: Converter answers one cycle after each start.
// Notes: Samples of each channel step through six codes.
`timescale 1ns/100ps
module test_tacs_sequencer import tacs_pkg::*;;
	logic core_clk = 1'b0, srst = 1'b1, sclPin, sdaPull, sdaOut, sdaOe;
	logic penSensePin = 1'b0, penTouchN, oscOn, driverOn, convStart;
	logic convDone = 1'b0;
	logic [3:0] convChan;
	logic [11:0] convData = 12'h000;
	logic [2:0] k = 3'h0; // Sample step, wraps after six.
	logic [7:0] d [4]; // Bytes of the last read burst.
	int mismatches = 0, checked = 0;
	wire sdaPin = !(sdaPull | sdaOe); // Pull-up on the data wire.
	initial forever #50 core_clk = ~core_clk;
	tacs_host_model tacs_host_model_inst (.core_clk(core_clk),
		.sdaPin(sdaPin), .sclPin(sclPin), .sdaPull(sdaPull));
	tacs_sequencer #(.LONG_SPACE(60)) tacs_sequencer_inst (
		.core_clk(core_clk), .srst(srst), .sclPin(sclPin),
		.sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOe(sdaOe), .cad0Pin(1'b0),
		.penSensePin(penSensePin), .penTouchN(penTouchN), .oscOn(oscOn),
		.driverOn(driverOn), .convStart(convStart), .convChan(convChan),
		.convDone(convDone), .convData(convData));
	// Converter stand-in: the code steps so trimming has an effect.
	always @(posedge core_clk) begin
		convDone <= convStart;
		if (convStart) begin
			convData <= {convChan, 8'h4c} + {9'h000, k};
			k <= (k == 3'h5) ? 3'h0 : k + 3'h1;
		end
	end
	task automatic give_verdict();
		$display("Counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Compares off the edge, then realigns to the driving edge.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		@(negedge core_clk);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
		@(posedge core_clk);
	endtask : check
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		logic [7:0] r;
		logic s;
		tacs_host_model_inst.start();
		tacs_host_model_inst.xbyte(8'h90, 1'b1, r, s);
		tacs_host_model_inst.xbyte(p, 1'b1, r, s);
		tacs_host_model_inst.xbyte(v, 1'b1, r, s);
		tacs_host_model_inst.stop();
	endtask : wr
	// Pointer write, repeated start, n bytes, nack on the last.
	task automatic rd(input logic [7:0] p, input int n);
		logic [7:0] r;
		logic s;
		tacs_host_model_inst.start();
		tacs_host_model_inst.xbyte(8'h90, 1'b1, r, s);
		tacs_host_model_inst.xbyte(p, 1'b1, r, s);
		tacs_host_model_inst.start();
		tacs_host_model_inst.xbyte(8'h91, 1'b1, r, s);
		for (int i = 0; i < n; i++) begin
			tacs_host_model_inst.xbyte(8'hff, 1'(i == n - 1), d[i], s);
		end
		tacs_host_model_inst.stop();
	endtask : rd
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		repeat (3) @(posedge core_clk);
		tacs_host_model_inst.stop();
		check({7'h00, sdaOut}, 8'h00); // Open-drain value stays low.
		wr(REG_SEQCMD, 8'h11);
		check({7'h00, penTouchN}, 8'h00);
		check({7'h00, oscOn}, 8'h01);
		rd(REG_STATUS, 1);
		check(d[0] & 8'h0f, {4'h0, ST_BUSY});
		for (int i = 0; i < 3000 && penTouchN !== 1'b1; i++) begin
			@(negedge core_clk);
		end
		if (penTouchN !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
		repeat (188) @(posedge core_clk);
		check({7'h00, oscOn}, 8'h01);
		repeat (20) @(posedge core_clk);
		check({7'h00, oscOn}, 8'h00);
		rd(REG_STATUS, 1);
		check(d[0] & 8'h0f, {4'h0, ST_AVAIL});
		rd(REG_SEQ_FIRST, 4);
		check(d[0], 8'h44);
		check(d[1], 8'he0);
		check(d[2], 8'h54);
		check(d[3], 8'he0);
		rd(REG_STATUS, 1);
		check(d[0] & 8'h0f, {4'h0, ST_IDLE});
		rd(REG_SEQ_FIRST, 1);
		check(d[0], 8'h00);
		$display("Test sequence mode done");
		penSensePin <= 1'b1;
		repeat (6) @(posedge core_clk);
		check({7'h00, penTouchN}, 8'h00);
		penSensePin <= 1'b0;
		repeat (6) @(posedge core_clk);
		check({7'h00, penTouchN}, 8'h01);
		rd(REG_SGL_FIRST, 4);
		check(d[0], 8'h44);
		check(d[1], 8'hc0);
		check(d[2], 8'h44);
		check(d[3], 8'hd0);
		rd(8'h05, 1);
		check(d[0], 8'h00);
		$display("Test single mode done");
		wr(REG_CFG, 8'h01);
		check({7'h00, driverOn}, 8'h01);
		check({7'h00, penTouchN}, 8'h00);
		wr(REG_CFG, 8'h00);
		check({7'h00, driverOn}, 8'h00);
		check({7'h00, penTouchN}, 8'h01);
		$display("Test driver hold done");
		give_verdict();
	end
endmodule : test_tacs_sequencer
